//--- vsss_pkg.sv
// Package for the VID and sleep-mode setpoint selector
package vsss_pkg;
    // Widths, target voltages in millivolts and timing
    localparam int          VID_W          = 6;
    localparam int          MV_W           = 11;
    localparam logic [10:0] VID_TOP_MV     = 11'h6ac;  // 1708 mV
    localparam logic [10:0] VID_STEP_MV    = 11'h010;  // 16 mV
    localparam int          SETTLE_NS      = 10000;    // 10 us
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
    localparam int          SETTLE_W       = 10;
    localparam int          MASK_CYC       = 16;
    localparam int          MASK_W         = 5;

    typedef enum logic [2:0] {
        VSSS_BOOT   = 3'b000,
        VSSS_WAIT   = 3'b001,
        VSSS_RUN    = 3'b011
    } vsss_state_t;

    typedef enum logic [1:0] {
        VSSS_MODE_ACTIVE  = 2'h0,
        VSSS_MODE_DEEP    = 2'h1,
        VSSS_MODE_DEEPER  = 2'h2
    } vsss_mode_t;

    typedef struct packed {
        logic [MV_W-1:0] target_mv;
        vsss_mode_t      mode;
        logic            diode_emul;
        logic            two_channel;
        logic            booting;
    } vsss_status_t;
endpackage

//--- vsss_sys_model.sv
// System power-management logic driving the VID, sleep and power-good pins
module vsss_sys_model
    import vsss_pkg::*;
(
    input  wire logic             i_clock,
    input  wire logic [VID_W-1:0] i_vid_req,
    input  wire logic             i_stop_n_req,
    input  wire logic             i_deeper_req,
    input  wire logic             i_release_req,
    input  wire logic             i_wire_sel,
    input  wire logic             i_power_ok_oe,
    output logic [VID_W-1:0]      o_volt_id,
    output logic                  o_stop_cpu_n,
    output logic                  o_deeper_sleep,
    output logic                  o_channel_count_sel,
    output logic                  o_power_ok_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic released_reg;
    always_ff @(posedge i_clock) begin
        o_volt_id      <= i_vid_req;
        o_stop_cpu_n   <= i_stop_n_req;
        o_deeper_sleep <= i_deeper_req;
        released_reg   <= i_release_req;
    end
    // Board wiring choice of the channel select
    assign o_channel_count_sel = i_wire_sel ? ~o_deeper_sleep
                                            : o_stop_cpu_n;
    // Pulled up; low while any party pulls it
    assign o_power_ok_line = released_reg & ~i_power_ok_oe;
endmodule // vsss_sys_model

//--- vsss_top.sv
// VID decode, sleep mode select, boot handover and power-good masking
//
// What this block does
// - A 6-bit VID code maps to 1708 mV minus 16 mV per step, down to 700.
// - After start-up, stop-cpu high and deeper-sleep low gives active mode.
// - After start-up, in active mode the target follows every new VID code.
// - After start-up, both sleep inputs low gives deep sleep, its setpoint, diode mode.
// - After start-up, deeper-sleep high gives deeper sleep and its setpoint.
// - Power-good out is held low while the target moves between codes.
// - During start-up the target is the boot setpoint.
// - After the shared power-good rises, wait 10 us then go to VID.
// - Overcurrent flags when sampled current is at or above threshold.
// - Channel select high runs two channels, low runs one.
module vsss_top
    import vsss_pkg::*;
#(
    parameter int CUR_W = 12
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic [VID_W-1:0]  i_volt_id,
    input  wire logic              i_stop_cpu_n_in,
    input  wire logic              i_deeper_sleep_in,
    input  wire logic              i_channel_count_sel,
    input  wire logic [MV_W-1:0]   i_boot_setpoint,
    input  wire logic [MV_W-1:0]   i_deep_sleep_setpoint,
    input  wire logic [MV_W-1:0]   i_deeper_sleep_setpoint,
    input  wire logic              i_power_ok_line,
    input  wire logic              i_output_in_window,
    input  wire logic [CUR_W-1:0]  i_sampled_current,
    input  wire logic [CUR_W-1:0]  i_overcurrent_threshold_ref,
    output logic [MV_W-1:0]        o_target_mv,
    output logic [MV_W-1:0]        o_decoded_target_voltage,
    output vsss_mode_t             o_mode,
    output logic                   o_diode_emul,
    output logic                   o_two_channel,
    output logic                   o_booting,
    output logic                   o_power_ok_out,
    output logic                   o_power_ok_oe,
    output logic                   o_overcurrent
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers
    logic [VID_W-1:0] vid_s1_reg, vid_s2_reg;
    logic [2:0]       ctl_s1_reg, ctl_s2_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            vid_s1_reg <= '0;
            vid_s2_reg <= '0;
            ctl_s1_reg <= '0;
            ctl_s2_reg <= '0;
        end else begin
            vid_s1_reg <= i_volt_id;
            vid_s2_reg <= vid_s1_reg;
            ctl_s1_reg <= {i_power_ok_line, i_deeper_sleep_in,
                           i_stop_cpu_n_in};
            ctl_s2_reg <= ctl_s1_reg;
        end
    end

    logic stop_n, deeper, pok_line;
    assign stop_n   = ctl_s2_reg[0];
    assign deeper   = ctl_s2_reg[1];
    assign pok_line = ctl_s2_reg[2];

    ////////////////////////////////////////////////////////////////////////
    // VID decode
    logic [MV_W-1:0] vid_mv;
    assign vid_mv = VID_TOP_MV
                    - MV_W'({5'h00, vid_s2_reg} * VID_STEP_MV);

    always_ff @(posedge i_clock) begin
        if (i_rst) o_decoded_target_voltage <= VID_TOP_MV;
        else       o_decoded_target_voltage <= vid_mv;
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot handover
    vsss_state_t           state_reg;
    logic [SETTLE_W-1:0]   settle_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg  <= VSSS_BOOT;
            settle_reg <= '0;
        end else begin
            case (state_reg)
                VSSS_BOOT: begin
                    settle_reg <= '0;
                    // Outside pull-up released the shared line
                    if (pok_line) state_reg <= VSSS_WAIT;
                end
                VSSS_WAIT: begin
                    if (settle_reg == SETTLE_W'(SETTLE_CYC - 1))
                        state_reg <= VSSS_RUN;
                    else
                        settle_reg <= settle_reg + 1'b1;
                end
                VSSS_RUN:  state_reg <= VSSS_RUN;
                default:   state_reg <= VSSS_BOOT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and target select
    vsss_status_t st_next;

    always_comb begin
        st_next.two_channel = i_channel_count_sel;
        st_next.booting     = (state_reg != VSSS_RUN);
        if (state_reg != VSSS_RUN) begin
            st_next.mode       = VSSS_MODE_ACTIVE;
            st_next.target_mv  = i_boot_setpoint;
            st_next.diode_emul = 1'b0;
        end else if (deeper) begin
            st_next.mode       = VSSS_MODE_DEEPER;
            st_next.target_mv  = i_deeper_sleep_setpoint;
            st_next.diode_emul = 1'b1;
        end else if (!stop_n) begin
            st_next.mode       = VSSS_MODE_DEEP;
            st_next.target_mv  = i_deep_sleep_setpoint;
            st_next.diode_emul = 1'b1;
        end else begin
            st_next.mode       = VSSS_MODE_ACTIVE;
            st_next.target_mv  = vid_mv;
            st_next.diode_emul = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_target_mv   <= '0;
            o_mode        <= VSSS_MODE_ACTIVE;
            o_diode_emul  <= 1'b0;
            o_two_channel <= 1'b0;
            o_booting     <= 1'b1;
        end else begin
            o_target_mv   <= st_next.target_mv;
            o_mode        <= st_next.mode;
            o_diode_emul  <= st_next.diode_emul;
            o_two_channel <= st_next.two_channel;
            o_booting     <= st_next.booting;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-good masking: any target or mode move restarts a blanking window
    logic [MASK_W-1:0] mask_reg;
    logic              moving;
    assign moving = (st_next.target_mv != o_target_mv)
                    || (st_next.mode != o_mode);

    always_ff @(posedge i_clock) begin
        if (i_rst)
            mask_reg <= '0;
        else if (moving)
            mask_reg <= MASK_W'(MASK_CYC);
        else if (mask_reg != '0)
            mask_reg <= mask_reg - 1'b1;
    end

    // Open drain: pin pulled low only while running and moving, masked or out of window
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_power_ok_out <= 1'b0;
            o_power_ok_oe  <= 1'b0;
        end else begin
            o_power_ok_out <= 1'b0;
            o_power_ok_oe  <= (state_reg == VSSS_RUN)
                              && (moving || mask_reg != '0
                                  || !i_output_in_window);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overcurrent compare
    always_ff @(posedge i_clock) begin
        if (i_rst) o_overcurrent <= 1'b0;
        else       o_overcurrent <= (i_sampled_current
                                     >= i_overcurrent_threshold_ref);
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_VID_DECODE: assert property (@(posedge i_clock) disable iff (i_rst)
        o_decoded_target_voltage == VID_TOP_MV
        - MV_W'({5'h00, $past(vid_s2_reg)} * VID_STEP_MV))
        else $error("VID decode wrong");
    AST_ACTIVE: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == VSSS_RUN && stop_n && !deeper) |=>
        (o_mode == VSSS_MODE_ACTIVE && o_target_mv == $past(vid_mv)))
        else $error("Active mode wrong");
    AST_FOLLOW: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == VSSS_RUN && stop_n && !deeper && $changed(vid_mv))
        |=> o_target_mv == $past(vid_mv))
        else $error("VID change not followed");
    AST_DEEP: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == VSSS_RUN && !stop_n && !deeper) |=>
        (o_diode_emul && o_mode == VSSS_MODE_DEEP))
        else $error("Deep sleep wrong");
    AST_DEEPER: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == VSSS_RUN && deeper) |=>
        (o_mode == VSSS_MODE_DEEPER
         && o_target_mv == $past(i_deeper_sleep_setpoint)))
        else $error("Deeper sleep wrong");
    AST_MASK: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == VSSS_RUN && moving) |=> o_power_ok_oe [*8])
        else $error("Power-good not masked");
    AST_BOOT: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg != VSSS_RUN) |=>
        o_target_mv == $past(i_boot_setpoint))
        else $error("Boot target wrong");
    AST_SETTLE: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == VSSS_BOOT && pok_line) |=>
        (state_reg == VSSS_WAIT) [*8])
        else $error("Handover too early");
    // Skip the edge right after reset: the flag still holds its reset value
    AST_OC: assert property (@(posedge i_clock) disable iff (i_rst)
        !$past(i_rst) |->
        o_overcurrent == ($past(i_sampled_current)
                          >= $past(i_overcurrent_threshold_ref)))
        else $error("Overcurrent flag wrong");
    AST_CHAN: assert property (@(posedge i_clock) disable iff (i_rst)
        !$past(i_rst) |->
        o_two_channel == $past(i_channel_count_sel))
        else $error("Channel count wrong");

endmodule // vsss_top

//--- vsss_top_bench.sv
// Self-checking bench for the VID and sleep-mode setpoint selector
module vsss_top_bench;
    import vsss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [10:0] BOOT = 11'h4b0, DEEP_SLEEP_SETPOINT = 11'h3e8, DEEPER_SLEEP_SETPOINT = 11'h320;
    logic i_clock = 1'b0, i_rst = 1'b1, stop_n = 1'b1, deeper = 1'b0;
    logic release_req = 1'b0, wire_sel = 1'b0, win = 1'b0;
    logic [5:0] vid_req = 6'h00;
    logic [11:0] cur = 12'h000, thr = 12'h100;
    logic [5:0] vid_pin;
    logic stop_pin, deeper_pin, ch_pin, pg_line;
    logic [10:0] tgt, dec;
    vsss_mode_t mode;
    logic diode, two_ch, booting, pg_out, pg_oe, ovc;
    int n_fail = 0, checks_done = 0, cycles = 0;
    vsss_top vsss_top_inst (.i_clock(i_clock), .i_rst(i_rst),
        .i_volt_id(vid_pin), .i_stop_cpu_n_in(stop_pin),
        .i_deeper_sleep_in(deeper_pin), .i_channel_count_sel(ch_pin),
        .i_boot_setpoint(BOOT), .i_deep_sleep_setpoint(DEEP_SLEEP_SETPOINT),
        .i_deeper_sleep_setpoint(DEEPER_SLEEP_SETPOINT), .i_power_ok_line(pg_line),
        .i_output_in_window(win), .i_sampled_current(cur),
        .i_overcurrent_threshold_ref(thr), .o_target_mv(tgt),
        .o_decoded_target_voltage(dec), .o_mode(mode),
        .o_diode_emul(diode), .o_two_channel(two_ch), .o_booting(booting),
        .o_power_ok_out(pg_out), .o_power_ok_oe(pg_oe), .o_overcurrent(ovc));
    vsss_sys_model vsss_sys_model_inst (.i_clock(i_clock),
        .i_vid_req(vid_req), .i_stop_n_req(stop_n), .i_deeper_req(deeper),
        .i_release_req(release_req), .i_wire_sel(wire_sel),
        .i_power_ok_oe(pg_oe), .o_volt_id(vid_pin), .o_stop_cpu_n(stop_pin),
        .o_deeper_sleep(deeper_pin), .o_channel_count_sel(ch_pin),
        .o_power_ok_line(pg_line));
    initial forever #10 i_clock = ~i_clock;
    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        // Boot handover is the long pole, some 520 cycles
        if (cycles == 4000) begin
            n_fail++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        int n;
        @(posedge i_clock);
        stop_n <= 1'b0;
        deeper <= 1'b1;
        vid_req <= 6'h05;
        cyc(8);
        chk("boot target", {5'h0, BOOT}, {5'h0, tgt});
        chk("boot mode", 16'h0, {14'h0, mode});
        chk("boot oe", 16'h0, {15'h0, pg_oe});
        chk("pok data", 16'h0, {15'h0, pg_out});
        @(posedge i_clock);
        stop_n <= 1'b1;
        deeper <= 1'b0;
        release_req <= 1'b1;
        cyc(SETTLE_CYC - 5);
        chk("still booting", 16'h1, {15'h0, booting});
        n = 0;
        while (booting !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        chk("handover", 16'h0, {15'h0, booting});
        cyc(2);
        chk("vid target", 16'h6ac - 16'h50, {5'h0, tgt});
        $display("boot test done");
    endtask
    task automatic t_vid(input logic [5:0] c);
        @(posedge i_clock);
        vid_req <= c;
        win <= 1'b1;
        cyc(7);
        chk("decoded", 16'h6ac - 16'(c) * 16'h10, {5'h0, dec});
        chk("target", 16'h6ac - 16'(c) * 16'h10, {5'h0, tgt});
        chk("mask oe", 16'h1, {15'h0, pg_oe});
        cyc(MASK_CYC + 10);
        chk("good oe", 16'h0, {15'h0, pg_oe});
        $display("vid test %h done", c);
    endtask
    task automatic t_mode(input logic s, d, w);
        logic [10:0] e;
        // VID code left at 6'h20 by the last VID test
        e = d ? DEEPER_SLEEP_SETPOINT : (s ? 11'h6ac - 11'h200 : DEEP_SLEEP_SETPOINT);
        @(posedge i_clock);
        stop_n <= s;
        deeper <= d;
        wire_sel <= w;
        cyc(8);
        chk("mode", d ? 16'h2 : (s ? 16'h0 : 16'h1), {14'h0, mode});
        chk("sel target", {5'h0, e}, {5'h0, tgt});
        chk("diode", {15'h0, ~s | d}, {15'h0, diode});
        chk("channels", {15'h0, w ? ~d : s}, {15'h0, two_ch});
        $display("mode test %b%b%b done", s, d, w);
    endtask
    task automatic t_ovc(input logic [11:0] c, input logic e);
        @(posedge i_clock);
        cur <= c;
        cyc(3);
        chk("overcurrent", {15'h0, e}, {15'h0, ovc});
        $display("overcurrent test %h done", c);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(10);
        @(posedge i_clock);
        i_rst <= 1'b0;
        t_boot();
        t_vid(6'h00);
        t_vid(6'h3f);
        t_vid(6'h01);
        t_vid(6'h20);
        for (int w = 0; w < 2; w++) begin
            t_mode(1'b0, 1'b0, w[0]);
            t_mode(1'b0, 1'b1, w[0]);
            t_mode(1'b1, 1'b1, w[0]);
            t_mode(1'b1, 1'b0, w[0]);
        end
        t_ovc(12'h0ff, 1'b0);
        t_ovc(12'h100, 1'b1);
        t_ovc(12'hfff, 1'b1);
        end_sim();
    end
endmodule // vsss_top_bench
